// [hw/adc_host_pkg.sv]
// constants and types shared by the converter end and the processor end
package adc_host_pkg;
    // clock and timing figures
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_MAX_NS = 10000;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int DATA_LEAD_NS = 600;
    localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAR_STEP_CYC = 16;
    localparam int READ_HOLD_CYC = 2;

    // data widths and bit positions
    localparam int RESULT_W = 12;
    localparam int BYTE_W = 8;
    localparam int NIBBLE_W = 4;
    localparam logic [3:0] MSB_POS = 4'hB;
    localparam logic [3:0] LONG_STOP_POS = 4'h0;
    localparam logic [3:0] SHORT_STOP_POS = 4'h4;

    // counter widths
    localparam int STEP_CNT_W = 5;
    localparam int WAIT_CNT_W = 9;

    // reset values
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

    // widest conversion must fit inside the guaranteed maximum time
    localparam int LONG_CONV_CYC = 12 * SAR_STEP_CYC + DATA_LEAD_CYC + 1;

    // how the processor learns that a conversion has ended
    typedef enum logic [1:0] {
        WAIT_POLL,
        WAIT_IRQ,
        WAIT_TIMEOUT
    } wait_mode_e;
endpackage

// [hw/adc_bus_if.sv]
// pins between the processor bus and the converter
`timescale 1ns/1ps
interface adc_bus_if;
    // control pins driven by the processor
    logic chip_enable;
    logic chip_select_n;
    logic read_not_convert;
    logic bus_width_sel;
    logic byte_select;
    // three-state result lines of the converter
    logic [adc_host_pkg::RESULT_W-1:0] result_bits_out;
    logic result_bits_oe_n;
    wire [adc_host_pkg::RESULT_W-1:0] result_bits;
    // status driven by the converter
    logic conversion_busy_flag;

    // resolved bus level: released lines read low, as if pulled down
    assign result_bits = result_bits_oe_n ? '0 : result_bits_out;

    modport converter (
        input chip_enable, chip_select_n, read_not_convert, bus_width_sel, byte_select,
        output result_bits_out, result_bits_oe_n, conversion_busy_flag
    );
    modport processor (
        output chip_enable, chip_select_n, read_not_convert, bus_width_sel, byte_select,
        input result_bits, conversion_busy_flag
    );
endinterface

// [hw/adc_converter_end.sv]
// successive-approximation converter control and its three-state result port
`timescale 1ns/1ps
module adc_converter_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // processor pins
    adc_bus_if.converter bus,
    // analog front end side
    input wire logic [adc_host_pkg::RESULT_W-1:0] sample_code,
    output logic sample_hold,
    output logic [adc_host_pkg::RESULT_W-1:0] converted_code
);

    typedef enum logic [1:0] {
        CV_IDLE,
        CV_CONVERT,
        CV_SETTLE
    } conv_state_e;

    conv_state_e state_q;
    conv_state_e state_d;
    logic [adc_host_pkg::RESULT_W-1:0] held_q;
    logic [adc_host_pkg::RESULT_W-1:0] sar_q;
    logic [adc_host_pkg::RESULT_W-1:0] sar_d;
    logic [3:0] bit_q;
    logic [3:0] stop_q;
    logic [adc_host_pkg::STEP_CNT_W-1:0] step_q;
    logic busy_q;
    logic data_ok_q;
    logic start_prev_q;
    logic [adc_host_pkg::RESULT_W-1:0] dout_q;
    logic oe_n_q;
    logic [adc_host_pkg::RESULT_W-1:0] result_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus cycle decode

    // a cycle needs chip enable high and chip select low together
    wire selected = bus.chip_enable & ~bus.chip_select_n;
    wire start_level = selected & ~bus.read_not_convert;
    wire read_cycle = selected & bus.read_not_convert;
    // only the leading cycle of a held strobe counts, so one write gives one start
    wire start_edge = start_level & ~start_prev_q;
    // a start while converting is dropped, not queued
    wire start_take = start_edge & (state_q == CV_IDLE);
    wire step_done = (step_q == 5'(adc_host_pkg::SAR_STEP_CYC - 1));
    wire settle_done = (step_q == 5'(adc_host_pkg::DATA_LEAD_CYC - 1));
    wire last_bit = (bit_q == stop_q);

    ////////////////////////////////////////////////////////////////////////////
    // successive approximation trial

    // set the bit under test and keep it if the trial does not exceed the held code
    wire [adc_host_pkg::RESULT_W-1:0] bit_mask = 12'h001 << bit_q;
    wire [adc_host_pkg::RESULT_W-1:0] trial = sar_q | bit_mask;
    wire keep_bit = (trial <= held_q);

    // next state and next approximation
    always_comb begin
        state_d = state_q;
        sar_d = sar_q;
        case (state_q)
            CV_IDLE: begin
                if (start_take) begin
                    state_d = CV_CONVERT;
                    sar_d = adc_host_pkg::RESULT_RST;
                end
            end
            CV_CONVERT: begin
                if (step_done) begin
                    sar_d = keep_bit ? trial : sar_q;
                    if (last_bit) begin
                        state_d = CV_SETTLE;
                    end
                end
            end
            CV_SETTLE: begin
                if (settle_done) begin
                    state_d = CV_IDLE;
                end
            end
            default: begin
                state_d = CV_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    // busy spans hold, all bit trials and the data lead interval
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= CV_IDLE;
            sar_q <= adc_host_pkg::RESULT_RST;
            busy_q <= 1'b0;
            start_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sar_q <= sar_d;
            busy_q <= (state_d != CV_IDLE);
            start_prev_q <= start_level;
        end
    end

    // sample held at the start; a short start stops after bit 4
    always_ff @(posedge core_clk) begin
        if (reset) begin
            held_q <= adc_host_pkg::RESULT_RST;
            stop_q <= adc_host_pkg::LONG_STOP_POS;
        end else if (start_take) begin
            held_q <= sample_code;
            stop_q <= bus.byte_select ? adc_host_pkg::SHORT_STOP_POS
                                      : adc_host_pkg::LONG_STOP_POS;
        end
    end

    // bit pointer walks from the top bit down, one step per trial period
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bit_q <= adc_host_pkg::MSB_POS;
        end else if (start_take) begin
            bit_q <= adc_host_pkg::MSB_POS;
        end else if (state_q == CV_CONVERT && step_done && !last_bit) begin
            bit_q <= bit_q - 4'h1;
        end
    end

    // one counter times both the trial steps and the final lead interval
    always_ff @(posedge core_clk) begin
        if (reset) begin
            step_q <= '0;
        end else if (state_q == CV_IDLE) begin
            step_q <= '0;
        end else if (state_q == CV_CONVERT && step_done) begin
            step_q <= '0;
        end else begin
            step_q <= step_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result latch and data availability

    // data becomes readable as the lead interval opens, before busy drops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_ok_q <= 1'b0;
            result_q <= adc_host_pkg::RESULT_RST;
        end else if (start_take) begin
            data_ok_q <= 1'b0;
        end else if (state_q == CV_CONVERT && state_d == CV_SETTLE) begin
            data_ok_q <= 1'b1;
            result_q <= sar_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output data formatting

    // narrow odd byte puts the low nibble on top with trailing zeros
    wire [adc_host_pkg::BYTE_W-1:0] hi_byte = result_q[11:4];
    wire [adc_host_pkg::BYTE_W-1:0] lo_byte = {result_q[3:0], 4'h0};
    wire [adc_host_pkg::BYTE_W-1:0] sel_byte = bus.byte_select ? lo_byte : hi_byte;
    wire [adc_host_pkg::RESULT_W-1:0] narrow_word = {4'h0, sel_byte};
    wire [adc_host_pkg::RESULT_W-1:0] dout_d = bus.bus_width_sel ? result_q
                                                                 : narrow_word;
    // lines stay released during the bit trials even if a read is attempted
    wire drive_d = read_cycle & data_ok_q;

    // registered drivers; the port lags the pins by one clock
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dout_q <= adc_host_pkg::RESULT_RST;
            oe_n_q <= 1'b1;
        end else begin
            dout_q <= dout_d;
            oe_n_q <= ~drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port connections

    // busy falls once per conversion, giving a clean completion edge
    assign bus.conversion_busy_flag = busy_q;
    assign bus.result_bits_out = dout_q;
    assign bus.result_bits_oe_n = oe_n_q;
    assign sample_hold = busy_q;
    assign converted_code = result_q;

endmodule

// [hw/adc_processor_end.sv]
// processor-side sequencer: starts a conversion, waits for it, reads the result
`timescale 1ns/1ps
module adc_processor_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // converter pins
    adc_bus_if.processor bus,
    // user request
    input wire logic start_req,
    input wire logic start_short,
    input wire logic wide_bus,
    input wire adc_host_pkg::wait_mode_e wait_mode,
    // user answer
    output logic busy,
    output logic [adc_host_pkg::RESULT_W-1:0] result,
    output logic result_valid,
    output logic done_irq
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_GAP,
        H_WAIT,
        H_READ_HI,
        H_READ_LO
    } host_state_e;

    host_state_e state_q;
    logic ce_q;
    logic cs_n_q;
    logic rnc_q;
    logic width_q;
    logic bsel_q;
    logic busy_prev_q;
    logic irq_q;
    logic valid_q;
    logic [adc_host_pkg::WAIT_CNT_W-1:0] cnt_q;
    logic [adc_host_pkg::RESULT_W-1:0] result_q;

    ////////////////////////////////////////////////////////////////////////////
    // completion detection

    wire busy_fall = busy_prev_q & ~bus.conversion_busy_flag;
    wire wait_over = (wait_mode == adc_host_pkg::WAIT_POLL) ? ~bus.conversion_busy_flag
                   : (wait_mode == adc_host_pkg::WAIT_IRQ) ? busy_fall
                   : (cnt_q >= 9'(adc_host_pkg::CONV_MAX_CYC));
    wire read_at = (cnt_q == 9'(adc_host_pkg::READ_HOLD_CYC - 1));
    // upper lines driven low on narrow reads and the trailing zeros are discarded
    wire [adc_host_pkg::RESULT_W-1:0] wide_word = bus.result_bits & 12'hFFF;
    wire [adc_host_pkg::NIBBLE_W-1:0] lo_nibble = bus.result_bits[7:4];

    ////////////////////////////////////////////////////////////////////////////
    // sequencer; pins change with the state so they come from flip-flops

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= H_IDLE;
            ce_q <= 1'b0;
            cs_n_q <= 1'b1;
            rnc_q <= 1'b1;
            width_q <= 1'b1;
            bsel_q <= 1'b0;
            cnt_q <= '0;
            result_q <= adc_host_pkg::RESULT_RST;
            valid_q <= 1'b0;
            irq_q <= 1'b0;
            busy_prev_q <= 1'b0;
        end else begin
            busy_prev_q <= bus.conversion_busy_flag;
            valid_q <= 1'b0;
            irq_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    // read-not-convert goes low with the select to avoid a stray read
                    if (start_req) begin
                        state_q <= H_START;
                        ce_q <= 1'b1;
                        cs_n_q <= 1'b0;
                        rnc_q <= 1'b0;
                        bsel_q <= start_short;
                        width_q <= wide_bus;
                    end
                end
                H_START: begin
                    state_q <= H_GAP;
                    cs_n_q <= 1'b1;
                    ce_q <= 1'b0;
                    rnc_q <= 1'b1;
                end
                H_GAP: begin
                    state_q <= H_WAIT;
                    cnt_q <= 9'h002;
                end
                H_WAIT: begin
                    cnt_q <= cnt_q + 9'h001;
                    // no read is issued before completion is known
                    if (wait_over) begin
                        state_q <= H_READ_HI;
                        irq_q <= (wait_mode == adc_host_pkg::WAIT_IRQ);
                        ce_q <= 1'b1;
                        cs_n_q <= 1'b0;
                        bsel_q <= 1'b0;
                        cnt_q <= '0;
                    end
                end
                H_READ_HI: begin
                    cnt_q <= cnt_q + 9'h001;
                    if (read_at) begin
                        cnt_q <= '0;
                        if (width_q) begin
                            result_q <= wide_word;
                            state_q <= H_IDLE;
                            valid_q <= 1'b1;
                            ce_q <= 1'b0;
                            cs_n_q <= 1'b1;
                        end else begin
                            result_q[11:4] <= bus.result_bits[7:0];
                            state_q <= H_READ_LO;
                            bsel_q <= 1'b1;
                        end
                    end
                end
                H_READ_LO: begin
                    cnt_q <= cnt_q + 9'h001;
                    if (read_at) begin
                        result_q[3:0] <= lo_nibble;
                        state_q <= H_IDLE;
                        valid_q <= 1'b1;
                        ce_q <= 1'b0;
                        cs_n_q <= 1'b1;
                        bsel_q <= 1'b0;
                        cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port connections

    assign bus.chip_enable = ce_q;
    assign bus.chip_select_n = cs_n_q;
    assign bus.read_not_convert = rnc_q;
    assign bus.bus_width_sel = width_q;
    assign bus.byte_select = bsel_q;
    assign busy = (state_q != H_IDLE);
    assign result = result_q;
    assign result_valid = valid_q;
    assign done_irq = irq_q;

endmodule

// [sim/adc_host_asserts.sv]
// pin-level checks between the processor end and the converter end
`timescale 1ns/1ps
module adc_host_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // processor pins
    input wire logic chip_enable,
    input wire logic chip_select_n,
    input wire logic read_not_convert,
    input wire logic bus_width_sel,
    input wire logic byte_select,
    // converter pins
    input wire logic [adc_host_pkg::RESULT_W-1:0] result_bits_out,
    input wire logic result_bits_oe_n,
    input wire logic conversion_busy_flag
);
    localparam int CONV_MAX = adc_host_pkg::CONV_MAX_CYC;
    // busy is seen high for every trial cycle plus the lead interval
    localparam int LONG_LEN = 12 * adc_host_pkg::SAR_STEP_CYC + adc_host_pkg::DATA_LEAD_CYC;
    localparam int SHORT_LEN = 8 * adc_host_pkg::SAR_STEP_CYC + adc_host_pkg::DATA_LEAD_CYC;
    logic [8:0] busy_cnt_q;
    logic [8:0] busy_cnt_d;
    logic busy_prev_q;
    logic bsel_prev_q;
    logic short_q;
    logic short_d;
    wire logic rd_sel;
    wire logic cv_sel;
    wire logic [8:0] exp_len;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the pins; conversion length is latched where busy rises
    assign rd_sel = chip_enable & ~chip_select_n & read_not_convert;
    assign cv_sel = chip_enable & ~chip_select_n & ~read_not_convert;
    assign busy_cnt_d = conversion_busy_flag ? busy_cnt_q + 9'h001 : 9'h000;
    assign short_d = (conversion_busy_flag & ~busy_prev_q) ? bsel_prev_q : short_q;
    assign exp_len = short_q ? 9'(SHORT_LEN) : 9'(LONG_LEN);

    // busy length counter, cleared so a mid-run reset cannot skew it
    always_ff @(posedge core_clk) begin
        busy_cnt_q <= reset ? 9'h000 : busy_cnt_d;
        busy_prev_q <= reset ? 1'b0 : conversion_busy_flag;
        bsel_prev_q <= byte_select;
        short_q <= reset ? 1'b0 : short_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_start_sets_busy: assert property (
        $rose(cv_sel) && !conversion_busy_flag |=> conversion_busy_flag)
        else $error("convert pins did not raise busy");
    chk_busy_bounded: assert property (
        $rose(conversion_busy_flag) |-> ##[1:CONV_MAX] !conversion_busy_flag)
        else $error("busy outlasted the maximum conversion time");
    chk_busy_length: assert property (
        $fell(conversion_busy_flag) |-> busy_cnt_q == exp_len)
        else $error("busy length does not match conversion length");
    chk_busy_holds: assert property (
        $rose(conversion_busy_flag) |-> conversion_busy_flag [*8])
        else $error("busy dropped right after start");
    chk_lines_float: assert property (
        !rd_sel [*3] |=> result_bits_oe_n)
        else $error("result lines driven without a read");
    chk_drive_needs_read: assert property (
        !result_bits_oe_n |-> $past(rd_sel) || $past(rd_sel, 2))
        else $error("result lines enabled with no read before");
    chk_convert_no_drive: assert property (
        cv_sel |-> ##2 result_bits_oe_n)
        else $error("convert cycle left result lines driven");
    chk_odd_byte_zero: assert property (
        !result_bits_oe_n && $past(rd_sel) && !$past(bus_width_sel) && $past(byte_select)
        |-> result_bits_out[3:0] == 4'h0 && result_bits_out[11:8] == 4'h0)
        else $error("odd byte trailing bits not zero");
    chk_even_upper_zero: assert property (
        !result_bits_oe_n && $past(rd_sel) && !$past(bus_width_sel) && !$past(byte_select)
        |-> result_bits_out[11:8] == 4'h0)
        else $error("even byte upper lines not zero");
endmodule

// [sim/testbench.sv]
// self-checking bench joining the processor end to the converter end
`timescale 1ns/1ps
module testbench;
    logic core_clk;
    logic reset;
    logic [11:0] sample_code;
    logic start_req;
    logic start_short;
    logic wide_bus;
    adc_host_pkg::wait_mode_e wait_mode;
    logic [11:0] converted_code;
    logic sample_hold;
    logic busy;
    logic [11:0] result;
    logic result_valid;
    logic done_irq;
    int n_errors;
    int n_tests;

    adc_bus_if bus_if ();

    ////////////////////////////////////////////////////////////////////////////
    // the two ends face each other on one interface
    adc_converter_end u_adc_converter_end (.core_clk(core_clk), .reset(reset), .bus(bus_if),
        .sample_code(sample_code), .sample_hold(sample_hold), .converted_code(converted_code));
    adc_processor_end u_adc_processor_end (.core_clk(core_clk), .reset(reset), .bus(bus_if),
        .start_req(start_req), .start_short(start_short), .wide_bus(wide_bus),
        .wait_mode(wait_mode), .busy(busy), .result(result), .result_valid(result_valid),
        .done_irq(done_irq));
    adc_host_asserts chk (.core_clk(core_clk), .reset(reset),
        .chip_enable(bus_if.chip_enable), .chip_select_n(bus_if.chip_select_n),
        .read_not_convert(bus_if.read_not_convert), .bus_width_sel(bus_if.bus_width_sel),
        .byte_select(bus_if.byte_select), .result_bits_out(bus_if.result_bits_out),
        .result_bits_oe_n(bus_if.result_bits_oe_n),
        .conversion_busy_flag(bus_if.conversion_busy_flag));

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // compare and count
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // user request, driven just after an edge
    task automatic set_req(input logic [11:0] code, input logic sh, input logic wd,
            input adc_host_pkg::wait_mode_e md);
        sample_code <= code;
        start_short <= sh;
        wide_bus <= wd;
        wait_mode <= md;
        start_req <= 1'b1;
    endtask

    // one conversion and read; hold keeps start_req up for a back-to-back start
    task automatic conv(input logic [11:0] code, input logic sh, input logic wd,
            input adc_host_pkg::wait_mode_e md, input logic hold);
        logic [11:0] exp;
        logic [11:0] seen;
        int irqs;
        int n;
        exp = sh ? {code[11:4], 4'h0} : code;
        seen = 12'hXXX;
        irqs = 0;
        n = 0;
        @(posedge core_clk);
        set_req(code, sh, wd, md);
        while (result_valid !== 1'b1 && n < 600) begin
            @(posedge core_clk);
            n++;
            if (!hold) begin
                start_req <= 1'b0;
            end
            if (done_irq === 1'b1) begin
                irqs++;
            end
            if (bus_if.conversion_busy_flag === 1'b1) begin
                check("user busy", 12'(busy), 12'h001);
                check("sample hold", 12'(sample_hold), 12'h001);
            end
            if (bus_if.result_bits_oe_n === 1'b0) begin
                seen = bus_if.result_bits;
            end
        end
        if (n >= 600) begin
            check("completion wait", 12'h000, 12'h001);
            report_and_stop();
        end
        check("result", result, exp);
        check("user busy done", 12'(busy), 12'h000);
        check("sample hold done", 12'(sample_hold), 12'h000);
        check("converted code", converted_code, exp);
        check("irq pulses", 12'(irqs), 12'((md == adc_host_pkg::WAIT_IRQ) ? 1 : 0));
        if (wd) begin
            check("wide word on lines", seen, exp);
        end
        if (!hold) begin
            repeat (3) @(posedge core_clk);
            check("released enable", 12'(bus_if.result_bits_oe_n), 12'h001);
            check("released lines", bus_if.result_bits, 12'h000);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one word read after a full conversion
    task automatic sc_wide_poll();
        conv(12'hA5C, 1'b0, 1'b1, adc_host_pkg::WAIT_POLL, 1'b0);
    endtask

    // two byte reads pair into one result
    task automatic sc_narrow_pair();
        conv(12'h3C9, 1'b0, 1'b0, adc_host_pkg::WAIT_POLL, 1'b0);
    endtask

    // short conversion at full scale, completion by interrupt
    task automatic sc_short_irq();
        conv(12'hFFF, 1'b1, 1'b1, adc_host_pkg::WAIT_IRQ, 1'b0);
    endtask

    // blind wait, short conversion, narrow bus; low nibble must vanish
    task automatic sc_timeout_narrow();
        conv(12'h00F, 1'b1, 1'b0, adc_host_pkg::WAIT_TIMEOUT, 1'b0);
    endtask

    // request held high: next start follows the read at once
    task automatic sc_back_to_back();
        conv(12'h800, 1'b0, 1'b1, adc_host_pkg::WAIT_POLL, 1'b1);
        conv(12'h800, 1'b0, 1'b1, adc_host_pkg::WAIT_IRQ, 1'b0);
    endtask

    // reset in mid-conversion clears busy and floats the lines
    task automatic sc_reset_mid();
        @(posedge core_clk);
        set_req(12'h555, 1'b0, 1'b1, adc_host_pkg::WAIT_POLL);
        repeat (2) @(posedge core_clk);
        start_req <= 1'b0;
        repeat (50) @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check("busy after reset", 12'(bus_if.conversion_busy_flag), 12'h000);
        check("enable after reset", 12'(bus_if.result_bits_oe_n), 12'h001);
        check("lines after reset", bus_if.result_bits, 12'h000);
    endtask

    // main sequence
    initial begin
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        sample_code = 12'h000;
        start_req = 1'b0;
        start_short = 1'b0;
        wide_bus = 1'b1;
        wait_mode = adc_host_pkg::WAIT_POLL;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        sc_wide_poll();
        sc_narrow_pair();
        sc_short_irq();
        sc_timeout_narrow();
        sc_back_to_back();
        sc_reset_mid();
        sc_wide_poll();
        report_and_stop();
    end
endmodule
